// ---- data_alu_regs.vh ----
/*
 holds the constants of the fixed-point data alu: operation codes, accumulator field layout,
 operand widths and reset values. assumes it is included by bare name into each file that uses its macros.
*/
`ifndef DATA_ALU_REGS_VH
`define DATA_ALU_REGS_VH

`define WORD_W        16
`define ACC_W         36
`define EXT_W         4
`define EXT_HI        35
`define EXT_LO        32
`define HIGH_HI       31
`define HIGH_LO       16
`define LOW_HI        15
`define LOW_LO        0
`define ACC_RESET     36'h000000000
`define ROUND_CONST   36'h000008000

`define OP_W          5
`define OP_NOP        5'h00
`define OP_ADD        5'h01
`define OP_SUB        5'h02
`define OP_CMP        5'h03
`define OP_AND        5'h04
`define OP_OR         5'h05
`define OP_XOR        5'h06
`define OP_ASL        5'h07
`define OP_ASR        5'h08
`define OP_LSL        5'h09
`define OP_LSR        5'h0a
`define OP_ROL        5'h0b
`define OP_ROR        5'h0c
`define OP_NOT        5'h0d
`define OP_WORD_INCREMENT       5'h0e
`define OP_WORD_DECREMENT       5'h0f
`define OP_MPY        5'h10
`define OP_MAC        5'h11
`define OP_FRACTIONAL_MULTIPLY_ROUNDED       5'h12
`define OP_FRACTIONAL_MAC_ROUNDED       5'h13
`define OP_IMPY       5'h14
`define OP_LOAD       5'h15
`define OP_DIV        5'h16
`define OP_WR_EXT     5'h17
`define OP_WR_HIGH    5'h18
`define OP_WR_LOW     5'h19
`define OP_MOVE_HIGH  5'h1a
`define OP_MOVE_LOW   5'h1b

`define DIV_STEPS     5'h10
`define DIV_CNT_W     5

`endif

// ---- div_step.v ----
/*
 holds one non-restoring division iteration on a 36-bit accumulator with a 16-bit divisor.
 assumes the caller repeats it sixteen times and keeps the quotient bits in the low part.
*/
`include "data_alu_regs.vh"
module div_step (
    input  wire [`ACC_W-1:0]  accIn,
    input  wire [`WORD_W-1:0] divisor,
    output wire [`ACC_W-1:0]  accOut
);
    wire [`ACC_W-1:0] shifted;
    wire [`ACC_W-1:0] dvExt;
    wire              quotBit;
    wire [`ACC_W-1:0] trial;

    assign dvExt   = {{(`EXT_W){divisor[`WORD_W-1]}}, divisor, {(`WORD_W){1'b0}}};
    // subtract when signs of remainder and divisor agree, otherwise add back
    assign quotBit = accIn[`EXT_HI] ^ divisor[`WORD_W-1];
    assign shifted = {accIn[`ACC_W-2:0], ~quotBit};
    assign trial   = quotBit ? shifted + dvExt : shifted - dvExt;
    assign accOut  = trial;
endmodule

// ---- fixed_point_data_alu.v ----
/*
 holds the fixed-point data alu: two 36-bit accumulators, add/sub/compare, logic, shifts,
 fractional and integer multiply, multiply-accumulate with rounding, and iterative division.
 assumes the program controller drives opValid with decoded op, operands and accumulator select
 on the same clock, and waits for busy low before issuing the next operation after a divide.
*/
//Contract
//- signed fractional words are one sign bit plus fifteen fraction bits
//- unsigned fractional words put binary point after the msb
//- signed integers span -32768..32767, long words up to 2147483647
//- unsigned integers put binary point right of the lsb
//- add, subtract and compare are the same bits for fraction and integer
//- word operands enter the high accumulator part before arithmetic
//- word destination results are correct in sixteen bits
//- and, or, xor and bit fields ignore number format
//- arithmetic left doubles, arithmetic right halves signed, logical right halves unsigned
//- fractional product is zero filled at the lsb
//- integer product gets an extra sign bit at the msb
//- fractional multiply forms a 32-bit product and accumulates into 36 bits
//- rounded multiplies round to sixteen bits and clear the low part
//- integer word multiply writes bits 31-16, sign extends, keeps low part
//- integer word multiply flags products beyond sixteen signed bits
//- single precision shifts, rotates, not, increment, decrement use bits 31-16; here increment and decrement carry on into bits 35-32
//- parallel moves reach the high part only, never the low part
//- fractional multiply then arithmetic right shift gives a full integer product
//- divide takes 32-bit dividend and 16-bit divisor, signed or positive
//- word writes land high, sign extend, clear low part
//- operands are 16, 32 or 36-bit two's complement
`include "data_alu_regs.vh"
module fixed_point_data_alu #(
    parameter N = 16
) (
    input  wire                clk,
    input  wire                rst_n,
    input  wire                opValid,
    input  wire [`OP_W-1:0]    opCode,
    input  wire                accSel,
    input  wire [N-1:0]        srcX,
    input  wire [N-1:0]        srcY,
    input  wire                srcAcc,
    input  wire                useAccSrc,
    output reg  [`ACC_W-1:0]   accA_r,
    output reg  [`ACC_W-1:0]   accB_r,
    output reg  [N-1:0]        wordResult_r,
    output reg                 resultValid_r,
    output reg                 overflow_r,
    output reg                 carry_r,
    output reg                 busy_r
);
    reg  [`ACC_W-1:0]     acc_nxt;
    reg  [`ACC_W-1:0]     accA_nxt;
    reg  [`ACC_W-1:0]     accB_nxt;
    reg  [N-1:0]          word_nxt;
    reg                   valid_nxt;
    reg                   ovf_nxt;
    reg                   carry_nxt;
    // divide sequencer: steps left, target accumulator and a latched divisor,
    // so the controller may change srcX while the steps run
    reg  [`DIV_CNT_W-1:0] divCnt_r;
    reg                   divAcc_r;
    reg  [N-1:0]          divisor_r;
    reg  [`DIV_CNT_W-1:0] divCnt_nxt;
    reg                   divAcc_nxt;
    reg  [N-1:0]          divisor_nxt;
    reg                   busy_nxt;
    // one bit wider than an accumulator to catch the carry out of bit 35
    reg  [`ACC_W:0]       sum;
    reg  [`ACC_W-1:0]     roundSum;

    wire [`ACC_W-1:0]     dstAcc;
    wire [`ACC_W-1:0]     otherAcc;
    wire [`ACC_W-1:0]     wordOperand;
    wire [`ACC_W-1:0]     srcOperand;
    wire [N-1:0]          accHigh;
    wire [2*N-1:0]        product;
    wire                  impyOverflow;
    wire [`ACC_W-1:0]     prodExt;
    wire [`ACC_W-1:0]     divAccIn;
    wire [`ACC_W-1:0]     divAccOut;

    // destination and second source are picked independently, so A+B, B+A and A+A all work
    assign dstAcc   = accSel ? accB_r : accA_r;
    assign otherAcc = srcAcc ? accB_r : accA_r;
    // a word joins the accumulator in its high part so the binary point stays aligned
    assign wordOperand = {{(`EXT_W){srcX[N-1]}}, srcX, {N{1'b0}}};
    assign srcOperand  = useAccSrc ? otherAcc : wordOperand;
    assign accHigh     = dstAcc[`HIGH_HI:`HIGH_LO];

    // one shared multiplier; only the integer word multiply asks for integer alignment
    signed_multiplier #(
        .N (N)
    ) u_mult (
        .opX          (srcX),
        .opY          (srcY),
        .fracMode     (opCode != `OP_IMPY),
        .product      (product),
        .wordOverflow (impyOverflow)
    );

    assign prodExt  = {{(`EXT_W){product[2*N-1]}}, product};
    assign divAccIn = divAcc_r ? accB_r : accA_r;

    // a single step instance is reused on each of the sixteen busy cycles,
    // trading divide latency for area
    div_step u_div (
        .accIn   (divAccIn),
        .divisor (divisor_r),
        .accOut  (divAccOut)
    );

    // operation decode: every next value except the valid pulse defaults to holding its register,
    // so only the fields an operation touches are listed in its branch
    always @* begin
        acc_nxt     = dstAcc;
        word_nxt    = wordResult_r;
        valid_nxt   = 1'b0;
        ovf_nxt     = overflow_r;
        carry_nxt   = carry_r;
        divCnt_nxt  = divCnt_r;
        divAcc_nxt  = divAcc_r;
        divisor_nxt = divisor_r;
        busy_nxt    = busy_r;
        sum         = {1'b0, `ACC_RESET};
        roundSum    = `ACC_RESET;
        if (opValid && !busy_r) begin
            valid_nxt = 1'b1;
            case (opCode)
                `OP_ADD: begin
                    // same adder for signed, unsigned, fraction and integer views
                    sum       = {1'b0, dstAcc} + {1'b0, srcOperand};
                    acc_nxt   = sum[`ACC_W-1:0];
                    carry_nxt = sum[`ACC_W];
                    ovf_nxt   = (dstAcc[`EXT_HI] == srcOperand[`EXT_HI]) &&
                                (sum[`EXT_HI] != dstAcc[`EXT_HI]);
                end
                `OP_SUB, `OP_CMP: begin
                    sum       = {1'b0, dstAcc} - {1'b0, srcOperand};
                    carry_nxt = sum[`ACC_W];
                    ovf_nxt   = (dstAcc[`EXT_HI] != srcOperand[`EXT_HI]) &&
                                (sum[`EXT_HI] != dstAcc[`EXT_HI]);
                    if (opCode == `OP_SUB) begin
                        acc_nxt = sum[`ACC_W-1:0];
                    end
                end
                `OP_AND: begin
                    acc_nxt[`HIGH_HI:`HIGH_LO] = accHigh & srcX;
                end
                `OP_OR: begin
                    acc_nxt[`HIGH_HI:`HIGH_LO] = accHigh | srcX;
                end
                `OP_XOR: begin
                    acc_nxt[`HIGH_HI:`HIGH_LO] = accHigh ^ srcX;
                end
                `OP_ASL: begin
                    acc_nxt   = {dstAcc[`ACC_W-2:0], 1'b0};
                    carry_nxt = dstAcc[`EXT_HI];
                end
                `OP_ASR: begin
                    // after a fractional multiply this yields the full integer product
                    acc_nxt   = {dstAcc[`EXT_HI], dstAcc[`ACC_W-1:1]};
                    carry_nxt = dstAcc[0];
                end
                `OP_LSL: begin
                    acc_nxt[`HIGH_HI:`HIGH_LO] = {accHigh[N-2:0], 1'b0};
                    carry_nxt = accHigh[N-1];
                end
                `OP_LSR: begin
                    acc_nxt[`HIGH_HI:`HIGH_LO] = {1'b0, accHigh[N-1:1]};
                    carry_nxt = accHigh[0];
                end
                // rotates go through the carry flag, seventeen bits in all
                `OP_ROL: begin
                    acc_nxt[`HIGH_HI:`HIGH_LO] = {accHigh[N-2:0], carry_r};
                    carry_nxt = accHigh[N-1];
                end
                `OP_ROR: begin
                    acc_nxt[`HIGH_HI:`HIGH_LO] = {carry_r, accHigh[N-1:1]};
                    carry_nxt = accHigh[0];
                end
                `OP_NOT: begin
                    acc_nxt[`HIGH_HI:`HIGH_LO] = ~accHigh;
                end
                // word steps act on the high part and may ripple into the extension
                `OP_WORD_INCREMENT: begin
                    acc_nxt = dstAcc + {{(`EXT_W){1'b0}}, {(N-1){1'b0}}, 1'b1, {N{1'b0}}};
                end
                `OP_WORD_DECREMENT: begin
                    acc_nxt = dstAcc - {{(`EXT_W){1'b0}}, {(N-1){1'b0}}, 1'b1, {N{1'b0}}};
                end
                // the fractional product always arrives zero filled at the lsb
                `OP_MPY, `OP_FRACTIONAL_MULTIPLY_ROUNDED, `OP_MAC, `OP_FRACTIONAL_MAC_ROUNDED: begin
                    if (opCode == `OP_MAC || opCode == `OP_FRACTIONAL_MAC_ROUNDED) begin
                        acc_nxt = dstAcc + prodExt;
                    end else begin
                        acc_nxt = prodExt;
                    end
                    if (opCode == `OP_FRACTIONAL_MULTIPLY_ROUNDED || opCode == `OP_FRACTIONAL_MAC_ROUNDED) begin
                        // round to nearest at bit 15, then drop the low part
                        roundSum = acc_nxt + `ROUND_CONST;
                        acc_nxt  = {roundSum[`EXT_HI:`HIGH_LO], {N{1'b0}}};
                    end
                    ovf_nxt = 1'b0;
                end
                // the low part is left alone; only the high word and its sign extension change
                `OP_IMPY: begin
                    acc_nxt = {{(`EXT_W){product[N-1]}}, product[N-1:0], dstAcc[`LOW_HI:`LOW_LO]};
                    ovf_nxt = impyOverflow;
                end
                `OP_LOAD, `OP_MOVE_HIGH: begin
                    acc_nxt = wordOperand;
                end
                // field writes go in raw, without sign extension or clearing
                `OP_WR_EXT: begin
                    acc_nxt[`EXT_HI:`EXT_LO] = srcX[`EXT_W-1:0];
                end
                `OP_WR_HIGH: begin
                    acc_nxt[`HIGH_HI:`HIGH_LO] = srcX;
                end
                `OP_WR_LOW: begin
                    acc_nxt[`LOW_HI:`LOW_LO] = srcX;
                end
                `OP_DIV: begin
                    // no answer now; the quotient is reported when the last step ends
                    divCnt_nxt  = `DIV_STEPS;
                    divAcc_nxt  = accSel;
                    divisor_nxt = srcX;
                    busy_nxt    = 1'b1;
                    valid_nxt   = 1'b0;
                end
                // unknown codes still answer, so the controller sees every accepted slot except a nop or a low move
                default: begin
                    valid_nxt = opCode != `OP_NOP;
                end
            endcase
            // destination word is the high part, limited when the extension holds growth
            if (acc_nxt[`EXT_HI:`HIGH_HI] == {(`EXT_W+1){acc_nxt[`EXT_HI]}}) begin
                word_nxt = acc_nxt[`HIGH_HI:`HIGH_LO];
            end else begin
                word_nxt = acc_nxt[`EXT_HI] ? {1'b1, {(N-1){1'b0}}} : {1'b0, {(N-1){1'b1}}};
            end
            // a low move never drives the low part onto the parallel move path
            if (opCode == `OP_MOVE_LOW) begin
                word_nxt  = wordResult_r;
                valid_nxt = 1'b0;
            end
        end else if (busy_r) begin
            // any request while busy is dropped without an answer
            divCnt_nxt = divCnt_r - {{(`DIV_CNT_W-1){1'b0}}, 1'b1};
            if (divCnt_r == {{(`DIV_CNT_W-1){1'b0}}, 1'b1}) begin
                busy_nxt  = 1'b0;
                valid_nxt = 1'b1;
                word_nxt  = divAccOut[`LOW_HI:`LOW_LO];
            end
        end
    end

    // accumulator write-back: the divider owns its accumulator while busy,
    // otherwise the decoded result goes to the selected one
    always @* begin
        accA_nxt = accA_r;
        accB_nxt = accB_r;
        if (busy_r) begin
            if (divAcc_r) begin
                accB_nxt = divAccOut;
            end else begin
                accA_nxt = divAccOut;
            end
        end else if (opValid) begin
            if (accSel) begin
                accB_nxt = acc_nxt;
            end else begin
                accA_nxt = acc_nxt;
            end
        end
    end

    // every output is a flip-flop; reset clears both accumulators and all flags
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            accA_r        <= `ACC_RESET;
            accB_r        <= `ACC_RESET;
            wordResult_r  <= {N{1'b0}};
            resultValid_r <= 1'b0;
            overflow_r    <= 1'b0;
            carry_r       <= 1'b0;
            busy_r        <= 1'b0;
            divCnt_r      <= {`DIV_CNT_W{1'b0}};
            divAcc_r      <= 1'b0;
            divisor_r     <= {N{1'b0}};
        end else begin
            accA_r        <= accA_nxt;
            accB_r        <= accB_nxt;
            wordResult_r  <= word_nxt;
            resultValid_r <= valid_nxt;
            overflow_r    <= ovf_nxt;
            carry_r       <= carry_nxt;
            busy_r        <= busy_nxt;
            divCnt_r      <= divCnt_nxt;
            divAcc_r      <= divAcc_nxt;
            divisor_r     <= divisor_nxt;
        end
    end
endmodule

// ---- fixed_point_data_alu_asserts.sv ----
/*
 checker of the fixed-point data alu: result and timing relations seen at the ports.
 assumes it is bound into fixed_point_data_alu and watches accumulator A and the request side.
*/
`include "data_alu_regs.vh"
module fixed_point_data_alu_asserts #(
    parameter N = 16
) (
    input wire                clk,
    input wire                rst_n,
    input wire                opValid,
    input wire [`OP_W-1:0]    opCode,
    input wire                accSel,
    input wire [N-1:0]        srcX,
    input wire [N-1:0]        srcY,
    input wire                useAccSrc,
    input wire [`ACC_W-1:0]   accA_r,
    input wire                resultValid_r,
    input wire                overflow_r,
    input wire                busy_r
);
    timeunit 1ns;
    timeprecision 1ps;
    wire               goA    = opValid && !busy_r && !accSel;
    wire signed [31:0] prod   = $signed(srcX) * $signed(srcY);
    wire [15:0]        prodLo = prod[15:0];
    wire               impyOv = (prod[31:15] != 17'h00000) && (prod[31:15] != 17'h1ffff);
    wire [35:0]        frac   = {{4{prod[30]}}, prod[30:0], 1'b0};
    wire [35:0]        word   = {{4{srcX[N-1]}}, srcX, 16'h0000};
    // -1.0 times -1.0 leaves the 32-bit product range, so it is kept out of the fractional product checks
    wire               edge16 = (srcX == 16'h8000) && (srcY == 16'h8000);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_addWord;
        goA && opCode == `OP_ADD && !useAccSrc |=> accA_r == $past(accA_r) + $past(word) && resultValid_r;
    endproperty
    a_addWord: assert property (p_addWord) else $error("word add result wrong");
    property p_load;
        goA && opCode == `OP_LOAD |=> accA_r == $past(word);
    endproperty
    a_load: assert property (p_load) else $error("word load not sign extended");
    property p_mpy;
        goA && opCode == `OP_MPY && !edge16 |=> accA_r == $past(frac);
    endproperty
    a_mpy: assert property (p_mpy) else $error("fractional product wrong");
    property p_mac;
        goA && opCode == `OP_MAC && !edge16 |=> accA_r == $past(accA_r) + $past(frac);
    endproperty
    a_mac: assert property (p_mac) else $error("accumulate result wrong");
    property p_fractional_multiply_rounded;
        goA && opCode == `OP_FRACTIONAL_MULTIPLY_ROUNDED && !edge16 |=> accA_r == (($past(frac) + `ROUND_CONST) & 36'hfffff0000);
    endproperty
    a_fractional_multiply_rounded: assert property (p_fractional_multiply_rounded) else $error("rounded product wrong");
    property p_impy;
        goA && opCode == `OP_IMPY |=> $stable(accA_r[15:0]) && accA_r[31:16] == $past(prodLo)
            && accA_r[35:32] == {4{accA_r[31]}};
    endproperty
    a_impy: assert property (p_impy) else $error("integer word product misplaced");
    property p_impyOvf;
        goA && opCode == `OP_IMPY |=> overflow_r == $past(impyOv);
    endproperty
    a_impyOvf: assert property (p_impyOvf) else $error("integer product overflow flag wrong");
    property p_asr;
        goA && opCode == `OP_ASR |=> $signed(accA_r) == ($signed($past(accA_r)) >>> 1);
    endproperty
    a_asr: assert property (p_asr) else $error("arithmetic right shift wrong");
    property p_lsl;
        goA && opCode == `OP_LSL |=> $stable(accA_r[15:0]) && accA_r[31:17] == $past(accA_r[30:16]) && !accA_r[16];
    endproperty
    a_lsl: assert property (p_lsl) else $error("high part shift wrong");
    property p_moveLow;
        goA && opCode == `OP_MOVE_LOW |=> $stable(accA_r) && !resultValid_r;
    endproperty
    a_moveLow: assert property (p_moveLow) else $error("low part move had an effect");
    property p_div;
        opValid && !busy_r && opCode == `OP_DIV |=> busy_r[*8] ##1 busy_r[*8] ##1 (!busy_r && resultValid_r);
    endproperty
    a_div: assert property (p_div) else $error("divide step timing wrong");

    cover property (goA && opCode == `OP_DIV);
    cover property (goA && opCode == `OP_MAC);
    cover property (goA && opCode == `OP_IMPY && impyOv);
endmodule

// ---- fixed_point_data_alu_tb.sv ----
/*
 testbench of the fixed-point data alu: hand-written scenarios through the controller model.
 assumes a 250 MHz clock and that results are visible half a cycle after the taking edge, at the next falling edge.
*/
`include "data_alu_regs.vh"
module fixed_point_data_alu_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        rst_n;
    wire         opValid, accSel, srcAcc, useAccSrc, resultValid_r, overflow_r, carry_r, busy_r;
    wire  [4:0]  opCode;
    wire  [15:0] srcX, srcY, wordResult_r;
    wire  [35:0] accA_r, accB_r;
    int          err_count, checks;
    logic [4:0]  sOp [7] = '{`OP_LSL, `OP_LSR, `OP_NOT, `OP_WORD_INCREMENT, `OP_WORD_DECREMENT, `OP_ROL, `OP_ROR};
    logic [15:0] sHi [7] = '{16'h8004, 16'h2001, 16'hbffd, 16'h4003, 16'h4001, 16'h8004, 16'h2001};

    fixed_point_data_alu #(.N(16)) DUT (.clk(clk), .rst_n(rst_n), .opValid(opValid), .opCode(opCode),
        .accSel(accSel), .srcX(srcX), .srcY(srcY), .srcAcc(srcAcc), .useAccSrc(useAccSrc), .accA_r(accA_r),
        .accB_r(accB_r), .wordResult_r(wordResult_r), .resultValid_r(resultValid_r), .overflow_r(overflow_r),
        .carry_r(carry_r), .busy_r(busy_r));
    op_controller_model u_ctl (.clk(clk), .busy(busy_r), .opValid(opValid), .opCode(opCode), .accSel(accSel),
        .srcX(srcX), .srcY(srcY), .srcAcc(srcAcc), .useAccSrc(useAccSrc));

    task chk(input string what, input [35:0] seen, input [35:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task op(input [4:0] c, input a, input [15:0] x, input [15:0] y);
        u_ctl.issue(c, a, x, y, 1'b0, 1'b0, 1'b1);
    endtask

    task t_formats;
        op(`OP_LOAD, 0, 16'h8000, 0);
        chk("loadMin", accA_r, 36'hf80000000);
        chk("loadValid", resultValid_r, 1);
        op(`OP_LOAD, 1, 16'h7fff, 0);
        chk("loadMax", accB_r, 36'h07fff0000);
        op(`OP_LOAD, 0, 16'hffff, 0);
        chk("loadOnes", accA_r, 36'hfffff0000);
    endtask
    task t_arith;
        op(`OP_LOAD, 0, 16'h04b1, 0);
        op(`OP_ADD, 0, 16'h004f, 0);
        chk("add", accA_r, 36'h005000000);
        op(`OP_SUB, 0, 16'h004f, 0);
        chk("sub", accA_r, 36'h004b10000);
        op(`OP_CMP, 0, 16'h0001, 0);
        chk("cmp", accA_r, 36'h004b10000);
        u_ctl.issue(`OP_ADD, 0, 16'h0000, 0, 1'b1, 1'b1, 1'b1);
        chk("addAcc", accA_r, 36'h084b00000);
        chk("wordLimit", wordResult_r, 16'h7fff);
    endtask
    task t_logic;
        op(`OP_LOAD, 0, 16'h0ff0, 0);
        op(`OP_AND, 0, 16'h3c3c, 0);
        chk("and", accA_r[31:16], 16'h0c30);
        op(`OP_OR, 0, 16'h3c3c, 0);
        chk("or", accA_r[31:16], 16'h3c3c);
        op(`OP_XOR, 0, 16'hffff, 0);
        chk("xor", accA_r[31:16], 16'hc3c3);
    endtask
    task t_shifts;
        for (int i = 0; i < 7; i++) begin
            op(`OP_LOAD, 0, 16'h4002, 0);
            op(`OP_WR_LOW, 0, 16'h1234, 0);
            op(sOp[i], 0, 0, 0);
            chk("singleLow", accA_r[15:0], 16'h1234);
            chk("singleHigh", accA_r[31:16], sHi[i]);
        end
        op(`OP_LOAD, 0, 16'h8001, 0);
        op(`OP_LSL, 0, 0, 0);
        chk("lslCarry", carry_r, 1);
        op(`OP_ROR, 0, 0, 0);
        chk("rorCarry", accA_r[31:16], 16'h8001);
        op(`OP_LOAD, 0, 16'h0003, 0);
        op(`OP_ASL, 0, 0, 0);
        chk("asl", accA_r[31:16], 16'h0006);
        op(`OP_LOAD, 0, 16'hfffa, 0);
        op(`OP_ASR, 0, 0, 0);
        chk("asr", accA_r, 36'hffffd0000);
        op(`OP_LOAD, 0, 16'h8000, 0);
        op(`OP_LSR, 0, 0, 0);
        chk("lsr", accA_r[31:16], 16'h4000);
    endtask
    task t_mult;
        op(`OP_MPY, 0, 16'h0004, 16'h0003);
        chk("mpy", accA_r, 36'd24);
        op(`OP_ASR, 0, 0, 0);
        chk("mpyAsr", accA_r, 36'd12);
        op(`OP_MPY, 0, 16'hfffc, 16'h0003);
        op(`OP_ASR, 0, 0, 0);
        chk("mpyAsrNeg", accA_r, 36'hffffffff4);
        op(`OP_WR_LOW, 0, 16'h5a5a, 0);
        op(`OP_IMPY, 0, 16'hfffc, 16'h0003);
        chk("impy", accA_r, 36'hffff45a5a);
        chk("impyOk", overflow_r, 0);
        op(`OP_IMPY, 0, 16'h4000, 16'h0004);
        chk("impyOvf", overflow_r, 1);
        op(`OP_FRACTIONAL_MULTIPLY_ROUNDED, 0, 16'h0001, 16'h4000);
        chk("fractional_multiply_rounded", accA_r, 36'h000010000);
        op(`OP_MAC, 0, 16'h0001, 16'h4000);
        chk("mac", accA_r, 36'h000018000);
        op(`OP_FRACTIONAL_MAC_ROUNDED, 0, 16'h0001, 16'h4000);
        chk("fractional_mac_rounded", accA_r, 36'h000020000);
    endtask
    task t_div;
        int n;
        op(`OP_LOAD, 1, 16'h1111, 0);
        op(`OP_LOAD, 0, 16'h0002, 0);
        u_ctl.issue(`OP_DIV, 0, 16'h4000, 0, 1'b0, 1'b0, 1'b1);
        chk("divBusy", busy_r, 1);
        u_ctl.issue(`OP_LOAD, 1, 16'h2222, 0, 1'b0, 1'b0, 1'b0);
        n = 3;
        while (busy_r && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk("divSteps", n, 17);
        chk("divDone", resultValid_r, 1);
        chk("refused", accB_r, 36'h011110000);
        chk("divQuot", wordResult_r[14:0], 15'h0004);
    endtask
    task t_fields;
        op(`OP_LOAD, 0, 16'h1234, 0);
        op(`OP_MOVE_LOW, 0, 16'habcd, 0);
        chk("moveLow", accA_r, 36'h012340000);
        chk("moveLowQuiet", resultValid_r, 0);
        op(`OP_MOVE_HIGH, 0, 16'h8001, 0);
        chk("moveHigh", accA_r, 36'hf80010000);
        op(`OP_WR_EXT, 0, 16'h0005, 0);
        chk("wrExt", accA_r, 36'h580010000);
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #200000;
        err_count++;
        print_verdict;
    end
    initial begin
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        chk("resetA", accA_r, 36'h0);
        chk("resetBusy", busy_r, 0);
        t_formats;
        t_arith;
        t_logic;
        t_shifts;
        t_mult;
        t_div;
        t_fields;
        print_verdict;
    end
endmodule

bind fixed_point_data_alu fixed_point_data_alu_asserts #(.N(N)) u_chk (.clk(clk), .rst_n(rst_n),
    .opValid(opValid), .opCode(opCode), .accSel(accSel), .srcX(srcX), .srcY(srcY), .useAccSrc(useAccSrc),
    .accA_r(accA_r), .resultValid_r(resultValid_r), .overflow_r(overflow_r), .busy_r(busy_r));

// ---- op_controller_model.sv ----
/*
 program controller model: issues one decoded data operation at a time.
 assumes the caller hands it operands; requests change only at the falling clock edge.
*/
module op_controller_model (
    input  wire        clk,
    input  wire        busy,
    output reg         opValid,
    output reg  [4:0]  opCode,
    output reg         accSel,
    output reg  [15:0] srcX,
    output reg  [15:0] srcY,
    output reg         srcAcc,
    output reg         useAccSrc
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {opValid, opCode, accSel, srcX, srcY, srcAcc, useAccSrc} = '0;
    end
    // holdOff low lets a request go out while busy, to exercise refusal
    task issue(input [4:0] c, input a, input [15:0] x, input [15:0] y, input sa, input ua, input holdOff);
        int n;
        begin
            n = 0;
            @(negedge clk);
            while (holdOff && busy && n < 100) begin
                @(negedge clk);
                n++;
            end
            opCode = c;
            accSel = a;
            srcX = x;
            srcY = y;
            srcAcc = sa;
            useAccSrc = ua;
            opValid = 1'b1;
            @(negedge clk);
            opValid = 1'b0;
            // stale operands are scrambled so nothing relies on them
            srcX = ~x;
            srcY = ~y;
        end
    endtask
endmodule

// ---- signed_multiplier.v ----
/*
 holds a combinational signed 16x16 multiplier that aligns its product for fractional or
 integer use. assumes operands are two's-complement words from logic on the same clock.
*/
module signed_multiplier #(
    parameter N = 16
) (
    input  wire [N-1:0]   opX,
    input  wire [N-1:0]   opY,
    input  wire           fracMode,
    output wire [2*N-1:0] product,
    output wire           wordOverflow
);
    wire signed [2*N-1:0] raw;

    assign raw = $signed(opX) * $signed(opY);
    // the raw value already carries the duplicated sign bit at the top (integer alignment);
    // shifting left by one drops it and zero fills the lsb (fractional alignment)
    assign product = fracMode ? {raw[2*N-2:0], 1'b0} : raw;
    // integer word result must fit in n signed bits
    assign wordOverflow = (raw[2*N-1:N-1] != {(N+1){1'b0}}) &&
                          (raw[2*N-1:N-1] != {(N+1){1'b1}});
endmodule
